/* irq_core_model.sv */
// Core sequencer model: takes each offered vector after dly cycles.
// Assumes irq_req from the controller; acks are one-cycle pulses.
`timescale 1ns/1ps
module irq_core_model
(
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       irq_req,
	input wire logic [1:0] dly,
	output logic           irq_ack
);
	logic [1:0] wait_q = 2'h0;
	initial irq_ack = 1'b0;
	always @(negedge mclk)
	begin
		wait_q <= (irq_req && !irq_ack) ? wait_q + 2'h1 : 2'h0;
		irq_ack <= !rst && irq_req && !irq_ack && wait_q >= dly;
	end
endmodule

/* irq_level_track.sv */
// Tracks which levels have a routine in service, as a nesting stack.
// Assumes the core signals entry and return once each, on mclk.
`timescale 1ns/1ps
module irq_level_track
(
	input  wire logic [3:0] cur,
	input  wire logic       enter,
	input  wire logic [1:0] enter_level,
	input  wire logic       leave,
	output logic [3:0]      nxt,
	output logic [1:0]      top,
	output logic            busy
);
	// Return closes the highest open level, so lower ones resume in turn
	always_comb
	begin
		logic [3:0] t;
		t    = cur;
		top  = 2'h0;
		busy = |cur;
		for (int i = 0; i < 4; i++)
		begin
			if (cur[i])
			begin
				top = 2'(i);
			end
		end
		if (leave && busy)
		begin
			t[top] = 1'b0;
		end
		if (enter)
		begin
			t[enter_level] = 1'b1;
		end
		nxt = t;
	end
endmodule

/* irq_pick.sv */
// Picks the winning source among pending requests.
// Assumes requests already gated by enables; pure combinational.
`timescale 1ns/1ps
`include "irq_prio_regs.svh"
module irq_pick
(
	input  wire logic [6:0] req,
	input  wire logic [6:0] lvl_hi,
	input  wire logic [6:0] lvl_lo,
	output logic            found,
	output logic [2:0]      src,
	output logic [1:0]      level
);
	logic [1:0] lvl [7];
	genvar g;
	generate
		for (g = 0; g < `NUM_SOURCES; g++)
		begin : g_lvl
			assign lvl[g] = {lvl_hi[g], lvl_lo[g]};
		end
	endgenerate

	// Strict greater-than keeps the earliest polled source on ties
	always_comb
	begin
		found = 1'b0;
		src   = 3'h0;
		level = 2'h0;
		for (int i = 0; i < `NUM_SOURCES; i++)
		begin
			if (req[i] && (!found || lvl[i] > level))
			begin
				found = 1'b1;
				src   = 3'(i);
				level = lvl[i];
			end
		end
	end
endmodule

/* irq_prio_checker.sv */
// Port checker for irq_prio_ctrl.
// Assumes it is bound to every irq_prio_ctrl instance.
`timescale 1ns/1ps
module irq_prio_checker
(
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       ext0_edge_mode,
	input wire logic       ext1_edge_mode,
	input wire logic       timer0_overflow_flag,
	input wire logic       irq_ack,
	input wire logic       irq_req,
	input wire logic [7:0] irq_vector,
	input wire logic [1:0] irq_level,
	input wire logic       clr_ext0,
	input wire logic       clr_timer0,
	input wire logic       clr_ext1,
	input wire logic       clr_timer1,
	input wire logic [3:0] in_service
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_take(v);
		irq_req && irq_ack && irq_vector == v;
	endsequence
	property p_drop;
		irq_req && irq_ack |=> !irq_req;
	endproperty
	a_drop: assert property (p_drop) else $error("request held after ack");
	property p_vec;
		irq_req |-> irq_vector inside {8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h33};
	endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
	property p_clr0;
		s_take(8'h0B) |=> clr_timer0;
	endproperty
	a_clr0: assert property (p_clr0) else $error("timer0 not cleared");
	property p_clr1;
		s_take(8'h1B) |=> clr_timer1;
	endproperty
	a_clr1: assert property (p_clr1) else $error("timer1 not cleared");
	property p_ext;
		s_take(8'h03) |=> clr_ext0 == $past(ext0_edge_mode);
	endproperty
	a_ext: assert property (p_ext) else $error("ext0 clear wrong");
	property p_ext1;
		s_take(8'h13) |=> clr_ext1 == $past(ext1_edge_mode);
	endproperty
	a_ext1: assert property (p_ext1) else $error("ext1 clear wrong");
	property p_enter;
		irq_req && irq_ack |=> in_service[$past(irq_level)];
	endproperty
	a_enter: assert property (p_enter) else $error("level not opened");
	property p_wait;
		irq_req |-> (in_service >> irq_level) == 4'h0;
	endproperty
	a_wait: assert property (p_wait) else $error("request not above service");
	property p_src;
		irq_req && irq_vector == 8'h0B |-> $past(timer0_overflow_flag);
	endproperty
	a_src: assert property (p_src) else $error("vector without flag");
endmodule
bind irq_prio_ctrl irq_prio_checker u_chk (.mclk, .rst, .ext0_edge_mode, .ext1_edge_mode,
	.timer0_overflow_flag, .irq_ack, .irq_req, .irq_vector, .irq_level, .clr_ext0, .clr_timer0,
	.clr_ext1, .clr_timer1, .in_service);

/* irq_prio_ctrl.sv */
// Four-level interrupt priority controller: registers, arbitration, vectoring.
// Assumes the core sequencer takes vectors with irq_ack and reports returns.
`timescale 1ns/1ps
`include "irq_prio_regs.svh"
module irq_prio_ctrl
	import irq_prio_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire irq_prio_pkg::sfr_req_t sfr,
	output logic [7:0]                 sfr_rdata,
	input  wire logic                  ext0_request_flag,
	input  wire logic                  ext0_edge_mode,
	input  wire logic                  timer0_overflow_flag,
	input  wire logic                  ext1_request_flag,
	input  wire logic                  ext1_edge_mode,
	input  wire logic                  timer1_overflow_flag,
	input  wire logic                  counter_array_overflow_flag,
	input  wire logic [4:0]            compare_module_flag,
	input  wire logic                  receive_complete_flag,
	input  wire logic                  transmit_complete_flag,
	input  wire logic                  timer2_overflow_flag,
	input  wire logic                  timer2_external_flag,
	input  wire logic                  irq_ack,
	input  wire logic                  irq_return,
	output logic                       irq_req,
	output logic [7:0]                 irq_vector,
	output logic [1:0]                 irq_level,
	output logic                       clr_ext0,
	output logic                       clr_timer0,
	output logic                       clr_ext1,
	output logic                       clr_timer1,
	output logic [3:0]                 in_service
);
	import irq_prio_pkg::*;

	ctrl_t      q;
	ctrl_t      d;
	logic [6:0] raw;
	logic [6:0] gated;
	logic [6:0] pl;
	logic [6:0] ph;
	logic       found;
	logic [2:0] win_src;
	logic [1:0] win_lvl;
	logic [3:0] isr_nxt;
	logic [1:0] isr_top;
	logic       isr_busy;
	logic       take;

	// Vector by source index, in polling order
	function automatic logic [7:0] vec_of(input logic [2:0] s);
		case (s)
			3'h0: vec_of = `VEC_EXT0;
			3'h1: vec_of = `VEC_TIMER0;
			3'h2: vec_of = `VEC_EXT1;
			3'h3: vec_of = `VEC_TIMER1;
			3'h4: vec_of = `VEC_COUNTER;
			3'h5: vec_of = `VEC_SERIAL;
			3'h6: vec_of = `VEC_TIMER2;
			default: vec_of = `VEC_EXT0;
		endcase
	endfunction

	// Map register bit layout (ext0,t0,ext1,t1,serial,t2,ctr) to polling order
	function automatic logic [6:0] to_poll(input logic [7:0] r);
		to_poll = {r[5], r[4], r[6], r[3], r[2], r[1], r[0]};
	endfunction

	// Request lines in polling order
	assign raw = {
		timer2_overflow_flag | timer2_external_flag,
		receive_complete_flag | transmit_complete_flag,
		counter_array_overflow_flag | (|compare_module_flag),
		timer1_overflow_flag,
		ext1_request_flag,
		timer0_overflow_flag,
		ext0_request_flag
	};

	assign gated = raw & to_poll(q.enable) & {7{q.enable[`BIT_GLOBAL_EN]}};
	assign pl    = to_poll(q.prio_low);
	assign ph    = to_poll(q.prio_high);

	irq_pick u_pick
	(
		.req    (gated),
		.lvl_hi (ph),
		.lvl_lo (pl),
		.found  (found),
		.src    (win_src),
		.level  (win_lvl)
	);

	assign take = q.irq_req && irq_ack;

	irq_level_track u_track
	(
		.cur         (q.in_service),
		.enter       (take),
		.enter_level (q.level),
		.leave       (irq_return),
		.nxt         (isr_nxt),
		.top         (isr_top),
		.busy        (isr_busy)
	);

	always_comb
	begin
		d = q;
		d.clear = 7'h00;
		d.in_service = isr_nxt;
		// Register writes
		if (sfr.wr)
		begin
			case (sfr.addr)
				`ADDR_ENABLE:    d.enable    = sfr.wdata;
				`ADDR_PRIO_LOW:  d.prio_low  = {1'b0, sfr.wdata[6:0]};
				`ADDR_PRIO_HIGH: d.prio_high = {1'b0, sfr.wdata[6:0]};
				default:         d.enable    = q.enable;
			endcase
		end
		// Reads return zero off-map and when idle so the core can merge buses
		d.rdata = 8'h00;
		if (sfr.rd)
		begin
			case (sfr.addr)
				`ADDR_ENABLE:    d.rdata = q.enable;
				`ADDR_PRIO_LOW:  d.rdata = q.prio_low;
				`ADDR_PRIO_HIGH: d.rdata = q.prio_high;
				default:         d.rdata = 8'h00;
			endcase
		end
		// Grant only above every open level; equal or lower waits
		if (take)
		begin
			d.irq_req = 1'b0;
			case (q.src)
				3'h0: d.clear[0] = ext0_edge_mode;
				3'h1: d.clear[1] = 1'b1;
				3'h2: d.clear[2] = ext1_edge_mode;
				3'h3: d.clear[3] = 1'b1;
				default: d.clear = 7'h00;
			endcase
		end
		else if (found && (!isr_busy || win_lvl > isr_top))
		begin
			d.irq_req = 1'b1;
			d.src     = win_src;
			d.level   = win_lvl;
			d.vector  = vec_of(win_src);
		end
		else
		begin
			d.irq_req = 1'b0;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	assign sfr_rdata  = q.rdata;
	assign irq_req    = q.irq_req;
	assign irq_vector = q.vector;
	assign irq_level  = q.level;
	assign clr_ext0   = q.clear[0];
	assign clr_timer0 = q.clear[1];
	assign clr_ext1   = q.clear[2];
	assign clr_timer1 = q.clear[3];
	assign in_service = q.in_service;
endmodule

/* irq_prio_pkg.sv */
// Types for the four-level interrupt priority controller.
// Assumes nothing beyond the constants header.
package irq_prio_pkg;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	typedef struct packed {
		logic [7:0] enable;
		logic [7:0] prio_low;
		logic [7:0] prio_high;
		logic [3:0] in_service;
		logic [7:0] rdata;
		logic       irq_req;
		logic [7:0] vector;
		logic [1:0] level;
		logic [2:0] src;
		logic [6:0] clear;
	} ctrl_t;

	typedef enum logic [1:0] {
		LVL0 = 2'b00,
		LVL1 = 2'b01,
		LVL2 = 2'b10,
		LVL3 = 2'b11
	} level_t;
endpackage

/* irq_prio_regs.svh */
// Constants for the four-level interrupt priority controller.
// Assumes the core decodes special-function addresses as 8-bit values.
`ifndef IRQ_PRIO_REGS_SVH
`define IRQ_PRIO_REGS_SVH
`define ADDR_ENABLE      8'hA8
`define ADDR_PRIO_LOW    8'hB8
`define ADDR_PRIO_HIGH   8'hB7
`define BIT_GLOBAL_EN    7
`define REG_RESET        8'h00
`define NUM_SOURCES      7
`define VEC_EXT0         8'h03
`define VEC_TIMER0       8'h0B
`define VEC_EXT1         8'h13
`define VEC_TIMER1       8'h1B
`define VEC_SERIAL       8'h23
`define VEC_TIMER2       8'h2B
`define VEC_COUNTER      8'h33
`endif

/* tb.sv */
// Testbench: registers, vectoring, polling order, nesting.
// Assumes the controller, its checker and the core model compiled first.
`timescale 1ns/1ps
module tb;
	import irq_prio_pkg::*;
	logic       mclk = 1'b0;
	logic       rst = 1'b1;
	sfr_req_t   sfr = '0;
	logic [7:0] rd, vec, v;
	logic [6:0] fl = '0;
	logic [3:0] ins;
	logic [1:0] lvl, dly;
	logic       e0m, e1m, sel, ack, req, c0, c1, c2, c3;
	logic       ret = 1'b0;
	logic [7:0] q[$];
	int         n_fail, checks, cyc, i;
	int         seed = 91340;
	int         ord[7] = '{0, 1, 2, 3, 6, 4, 5};
	always #4 mclk = ~mclk;
	irq_prio_ctrl DUT (.mclk, .rst, .sfr, .sfr_rdata(rd), .ext0_request_flag(fl[0]),
		.ext0_edge_mode(e0m), .timer0_overflow_flag(fl[1]), .ext1_request_flag(fl[2]),
		.ext1_edge_mode(e1m), .timer1_overflow_flag(fl[3]),
		.counter_array_overflow_flag(fl[6] & sel), .compare_module_flag({5{fl[6] & ~sel}}),
		.receive_complete_flag(fl[4] & sel), .transmit_complete_flag(fl[4] & ~sel),
		.timer2_overflow_flag(fl[5] & sel), .timer2_external_flag(fl[5] & ~sel),
		.irq_ack(ack), .irq_return(ret), .irq_req(req), .irq_vector(vec), .irq_level(lvl),
		.clr_ext0(c0), .clr_timer0(c1), .clr_ext1(c2), .clr_timer1(c3), .in_service(ins));
	irq_core_model core (.mclk, .rst, .irq_req(req), .dly, .irq_ack(ack));
	task chk(input string n, input logic [7:0] e, input logic [7:0] s);
		checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task finish_test;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk) sfr = '{1'b1, 1'b0, a, d};
		@(negedge mclk) sfr = '0;
	endtask
	task rdc(input logic [7:0] a, input logic [7:0] e);
		@(negedge mclk) sfr = '{1'b0, 1'b1, a, 8'h00};
		@(negedge mclk) chk("sfr_rdata", e, rd);
		sfr = '0;
	endtask
	task ret1;
		@(negedge mclk) ret = 1'b1;
		@(negedge mclk) ret = 1'b0;
	endtask
	// Waits for the core to take queued vectors; a stall shows as a leftover count
	task serve(input int left);
		for (int k = 0; k < 40 && q.size() > left; k++)
			@(negedge mclk);
		chk("pending", 8'(left), 8'(q.size()));
	endtask
	task go(input int b, input logic [3:0] e);
		q.push_back(8'(8'h03 + 8 * b));
		fl[b] = 1'b1;
		serve(0);
		fl[b] = 1'b0;
		chk("in_service", 8'(e), 8'(ins));
		chk("clear", {4'h0, b == 3, b == 2 && e1m, b == 1, b == 0 && e0m}, {4'h0, c3, c2, c1, c0});
	endtask
	always @(posedge mclk)
		if (req === 1'b1 && ack === 1'b1)
			chk("irq_vector", q.size() ? q.pop_front() : 8'hXX, vec);
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			n_fail++;
			finish_test;
		end
	end
	initial
	begin
		{sel, e0m, e1m, dly} = '0;
		repeat (10) @(negedge mclk);
		rst = 1'b0;
		rdc(8'hA8, 8'h00);
		rdc(8'hB8, 8'h00);
		rdc(8'hB7, 8'h00);
		v = 8'($random(seed));
		wr(8'hB7, v);
		rdc(8'hB7, v & 8'h7F);
		rdc(8'h99, 8'h00);
		wr(8'h99, 8'hFF);
		rdc(8'hA8, 8'h00);
		wr(8'hB7, 8'h00);
		$display("registers done");
		for (i = 0; i < 7; i++)
		begin
			{sel, e0m, e1m, dly} = 5'($random(seed));
			wr(8'hA8, 8'h01 << i);
			fl[i] = 1'b1;
			repeat (4) @(negedge mclk);
			chk("irq_req", 8'h00, {7'h00, req});
			wr(8'hA8, 8'h80 | (8'h01 << i));
			go(i, 4'h1);
			ret1;
		end
		$display("sources done");
		wr(8'hA8, 8'h00);
		fl = 7'h7F;
		foreach (ord[k])
			q.push_back(8'(8'h03 + 8 * ord[k]));
		wr(8'hA8, 8'hFF);
		foreach (ord[k])
		begin
			serve(6 - k);
			fl[ord[k]] = 1'b0;
			ret1;
		end
		$display("polling order done");
		wr(8'hB8, 8'h02);
		wr(8'hB7, 8'h0E);
		go(0, 4'h1);
		go(2, 4'h5);
		go(1, 4'hD);
		fl[3] = 1'b1;
		ret1;
		repeat (4) @(negedge mclk);
		chk("in_service", 8'h05, 8'(ins));
		q.push_back(8'h1B);
		ret1;
		serve(0);
		fl[3] = 1'b0;
		chk("in_service", 8'h05, 8'(ins));
		ret1;
		ret1;
		chk("in_service", 8'h00, 8'(ins));
		$display("nesting done");
		finish_test;
	end
endmodule
